// [rtl/fts_pkg.sv]
// constants for the fault and throttle status register pair
// assumes one 50 MHz core clock and a synchronous active-high reset
// Functional notes
// - terminator 2 sense asserted latches fault bit 3 until cleared
// - channel eight reading off the requested vid voltage sets fault bit 5
// - diode 1 open or short sets bit 6, diode 2 sets bit 7
// - any throttle duty above zero sets throttle bit 0
// - one band bit per duty sample, bits 1 to 6 by duty range
// - duty above user limit sets bit 7, the only host summary source
package fts_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] FAULT_OFS = 8'h4b;
    localparam logic [7:0] THROTTLE_OFS = 8'h4c;
    localparam logic [7:0] FAULT_RESET = 8'h00;
    localparam logic [7:0] THROTTLE_RESET = 8'h00;
    // bits 1:0 of the fault register are reserved and read zero
    localparam logic [7:0] FAULT_IMPL_MASK = 8'hfc;
    localparam logic [7:0] THROTTLE_IMPL_MASK = 8'hff;

    // ---------------------------------------------------------------
    // fault register fields
    // ---------------------------------------------------------------
    localparam int TERM1_BIT = 2;
    localparam int TERM2_BIT = 3;
    localparam int CORE1_BIT = 4;
    localparam int CORE2_BIT = 5;
    localparam int DIODE1_BIT = 6;
    localparam int DIODE2_BIT = 7;

    // ---------------------------------------------------------------
    // throttle register fields
    // ---------------------------------------------------------------
    localparam int SEEN_BIT = 0;
    localparam int BAND_LOW_BIT = 1;
    localparam int BAND_QUARTER_BIT = 2;
    localparam int BAND_HALF_BIT = 3;
    localparam int BAND_THREE_QUARTER_BIT = 4;
    localparam int BAND_HIGH_BIT = 5;
    localparam int FULL_BIT = 6;
    localparam int LIMIT_BIT = 7;

    // ---------------------------------------------------------------
    // duty code: 8'hff is full throttling, steps of 1/256
    // ---------------------------------------------------------------
    localparam logic [7:0] DUTY_ZERO = 8'h00;
    localparam logic [7:0] DUTY_12P5 = 8'h20;
    localparam logic [7:0] DUTY_25 = 8'h40;
    localparam logic [7:0] DUTY_50 = 8'h80;
    localparam logic [7:0] DUTY_75 = 8'hc0;
    localparam logic [7:0] DUTY_FULL = 8'hff;

    // ---------------------------------------------------------------
    // vid to expected reading map, linear, plain defaults
    // ---------------------------------------------------------------
    localparam logic [7:0] VID_BASE_CODE = 8'hc0;
    localparam logic [7:0] VID_STEP = 8'h02;
    localparam logic [7:0] VID_TOLERANCE = 8'h04;

endpackage

// [rtl/fts_sticky_if.sv]
// set, clear and state lines of one sticky status byte
// assumes both ends run on the same core clock
`timescale 1ns/1ns
interface fts_sticky_if;
    logic [7:0] set;
    logic [7:0] clr;
    logic [7:0] q;

    modport bank (
        input set,
        input clr,
        output q
    );

    modport ctrl (
        output set,
        output clr,
        input q
    );
endinterface

// [rtl/fts_sticky_byte.sv]
// one sticky status byte with write-one-to-clear
// assumes set and clear come from logic on core_clk
`timescale 1ns/1ns
module fts_sticky_byte #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] IMPL_MASK = 8'hff
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // status lines
    fts_sticky_if.bank bank
);
    import fts_pkg::*;

    logic [7:0] q_ff;
    wire logic [7:0] nxt_q;

    // set wins over a clear in the same cycle, so no event is lost
    assign nxt_q = ((q_ff & ~bank.clr) | bank.set) & IMPL_MASK;
    assign bank.q = q_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            q_ff <= RESET_VAL;
        end else begin
            q_ff <= nxt_q;
        end
    end
endmodule

// [rtl/fts_status_regs.sv]
// fault and throttle status registers with their set logic
// assumes the serial interface engine hands over byte reads and writes
// on core_clk, and that duty, diode and adc results are on core_clk too
`timescale 1ns/1ns
module fts_status_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // termination sense pins, asynchronous
    input wire logic term1_sense_input,
    input wire logic term2_sense_input,
    // vid pins, asynchronous
    input wire logic [5:0] cpu1_voltage_code,
    // converted analog readings
    input wire logic [7:0] analog_input_seven,
    input wire logic [7:0] analog_input_eight,
    input wire logic adc_sample_valid,
    // remote diode front end results
    input wire logic diode1_open,
    input wire logic diode1_short,
    input wire logic diode2_open,
    input wire logic diode2_short,
    input wire logic diode_sample_valid,
    // throttle duty measurement
    input wire logic [7:0] cpu1_duty,
    input wire logic cpu1_duty_valid,
    input wire logic [7:0] cpu1_duty_limit,
    // sleep states
    input wire logic sleep_s3,
    input wire logic sleep_s45,
    // register access from the serial engine
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_ack,
    // summary toward the status/control register
    output logic host_err_src,
    output logic fault_err_src
);
    import fts_pkg::*;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] term_meta_ff;
    logic [1:0] term_sync_ff;
    logic [5:0] vid_meta_ff;
    logic [5:0] vid_sync_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            term_meta_ff <= 2'h0;
            term_sync_ff <= 2'h0;
            vid_meta_ff <= 6'h00;
            vid_sync_ff <= 6'h00;
        end else begin
            term_meta_ff <= {term2_sense_input, term1_sense_input};
            term_sync_ff <= term_meta_ff;
            vid_meta_ff <= cpu1_voltage_code;
            vid_sync_ff <= vid_meta_ff;
        end
    end

    // ---------------------------------------------------------------
    // sleep masking
    // ---------------------------------------------------------------
    // every bit of both registers is masked in s3 and s4/5
    wire logic awake;
    assign awake = ~(sleep_s3 | sleep_s45);

    // ---------------------------------------------------------------
    // vid compare
    // ---------------------------------------------------------------
    // the vid lines may move while a reading is taken; the synchronised
    // copy is used, so a change shows at most two cycles late
    wire logic [7:0] vid_offset;
    wire logic [7:0] vid_expected;
    wire logic [7:0] diff_seven;
    wire logic [7:0] diff_eight;
    wire logic core1_off;
    wire logic core2_off;

    assign vid_offset = 8'({2'h0, vid_sync_ff} * VID_STEP);
    assign vid_expected = 8'(VID_BASE_CODE - vid_offset);
    assign diff_seven = (analog_input_seven > vid_expected) ?
        8'(analog_input_seven - vid_expected) : 8'(vid_expected - analog_input_seven);
    assign diff_eight = (analog_input_eight > vid_expected) ?
        8'(analog_input_eight - vid_expected) : 8'(vid_expected - analog_input_eight);
    assign core1_off = adc_sample_valid & (diff_seven > VID_TOLERANCE);
    // channel eight is held against the same vid code as channel seven
    assign core2_off = adc_sample_valid & (diff_eight > VID_TOLERANCE);

    // ---------------------------------------------------------------
    // fault set vector
    // ---------------------------------------------------------------
    wire logic diode1_bad;
    wire logic diode2_bad;
    logic [7:0] fault_raw;

    assign diode1_bad = diode_sample_valid & (diode1_open | diode1_short);
    assign diode2_bad = diode_sample_valid & (diode2_open | diode2_short);

    always_comb begin
        fault_raw = 8'h00;
        fault_raw[TERM1_BIT] = term_sync_ff[0];
        fault_raw[TERM2_BIT] = term_sync_ff[1];
        fault_raw[CORE1_BIT] = core1_off;
        fault_raw[CORE2_BIT] = core2_off;
        fault_raw[DIODE1_BIT] = diode1_bad;
        fault_raw[DIODE2_BIT] = diode2_bad;
    end

    // ---------------------------------------------------------------
    // throttle band decode
    // ---------------------------------------------------------------
    wire logic duty_seen;
    wire logic band_low;
    wire logic band_quarter;
    wire logic band_half;
    wire logic band_three_quarter;
    wire logic band_high;
    wire logic duty_full;
    wire logic over_limit;
    logic [7:0] throttle_raw;

    assign duty_seen = cpu1_duty > DUTY_ZERO;
    assign band_low = cpu1_duty < DUTY_12P5;
    assign band_quarter = (cpu1_duty >= DUTY_12P5) & (cpu1_duty < DUTY_25);
    assign band_half = (cpu1_duty >= DUTY_25) & (cpu1_duty < DUTY_50);
    assign band_three_quarter = (cpu1_duty >= DUTY_50) & (cpu1_duty < DUTY_75);
    assign band_high = (cpu1_duty >= DUTY_75) & (cpu1_duty < DUTY_FULL);
    assign duty_full = cpu1_duty == DUTY_FULL;
    assign over_limit = cpu1_duty > cpu1_duty_limit;

    always_comb begin
        throttle_raw = 8'h00;
        throttle_raw[SEEN_BIT] = duty_seen;
        throttle_raw[BAND_LOW_BIT] = band_low;
        throttle_raw[BAND_QUARTER_BIT] = band_quarter;
        throttle_raw[BAND_HALF_BIT] = band_half;
        throttle_raw[BAND_THREE_QUARTER_BIT] = band_three_quarter;
        throttle_raw[BAND_HIGH_BIT] = band_high;
        throttle_raw[FULL_BIT] = duty_full;
        throttle_raw[LIMIT_BIT] = over_limit;
    end

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    wire logic hit_fault;
    wire logic hit_throttle;
    wire logic hit_any;
    wire logic [7:0] rd_sel;

    assign hit_fault = reg_addr == FAULT_OFS;
    assign hit_throttle = reg_addr == THROTTLE_OFS;
    assign hit_any = hit_fault | hit_throttle;

    // ---------------------------------------------------------------
    // sticky banks
    // ---------------------------------------------------------------
    fts_sticky_if fault_if ();
    fts_sticky_if throttle_if ();

    assign fault_if.set = awake ? fault_raw : 8'h00;
    assign fault_if.clr = (reg_wr & hit_fault) ? reg_wdata : 8'h00;
    assign throttle_if.set = (awake & cpu1_duty_valid) ? throttle_raw : 8'h00;
    assign throttle_if.clr = (reg_wr & hit_throttle) ? reg_wdata : 8'h00;

    fts_sticky_byte #(
        .RESET_VAL(FAULT_RESET),
        .IMPL_MASK(FAULT_IMPL_MASK)
    ) u_fault (
        .core_clk(core_clk),
        .rst(rst),
        .bank(fault_if.bank)
    );

    fts_sticky_byte #(
        .RESET_VAL(THROTTLE_RESET),
        .IMPL_MASK(THROTTLE_IMPL_MASK)
    ) u_throttle (
        .core_clk(core_clk),
        .rst(rst),
        .bank(throttle_if.bank)
    );

    // ---------------------------------------------------------------
    // read path and summary
    // ---------------------------------------------------------------
    // read data shows the state before any clear of the same cycle
    assign rd_sel = hit_fault ? fault_if.q : (hit_throttle ? throttle_if.q : 8'h00);

    logic [7:0] reg_rdata_ff;
    logic reg_ack_ff;
    logic host_err_src_ff;
    logic fault_err_src_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata_ff <= 8'h00;
            reg_ack_ff <= 1'b0;
            host_err_src_ff <= 1'b0;
            fault_err_src_ff <= 1'b0;
        end else begin
            reg_rdata_ff <= reg_rd ? rd_sel : reg_rdata_ff;
            reg_ack_ff <= (reg_rd | reg_wr) & hit_any;
            // band bits are informative only; just the limit bit reaches the host
            host_err_src_ff <= throttle_if.q[LIMIT_BIT];
            fault_err_src_ff <= |fault_if.q;
        end
    end

    assign reg_rdata = reg_rdata_ff;
    assign reg_ack = reg_ack_ff;
    assign host_err_src = host_err_src_ff;
    assign fault_err_src = fault_err_src_ff;
endmodule

// [bench/fts_status_regs_properties.sv]
// checker for the status register pair, top ports only
// assumes one core clock and the synchronous reset of the design
`timescale 1ns/1ns
module fts_status_regs_chk
    import fts_pkg::*;
(
    // ---------------------------------------------------------------
    // watched ports
    // ---------------------------------------------------------------
    input wire logic core_clk, rst,
    input wire logic term1_sense_input, term2_sense_input,
    input wire logic [5:0] cpu1_voltage_code,
    input wire logic [7:0] analog_input_eight,
    input wire logic adc_sample_valid, diode1_open, diode1_short, diode_sample_valid,
    input wire logic [7:0] cpu1_duty, cpu1_duty_limit, reg_addr,
    input wire logic cpu1_duty_valid, sleep_s3, sleep_s45, reg_wr, reg_rd,
    input wire logic reg_ack, host_err_src, fault_err_src
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire awake = !sleep_s3 && !sleep_s45;
    wire acc = reg_rd || reg_wr;
    wire mapped = reg_addr == FAULT_OFS || reg_addr == THROTTLE_OFS;
    wire [7:0] vexp = VID_BASE_CODE - {1'b0, cpu1_voltage_code, 1'b0};
    wire [7:0] vdif = analog_input_eight > vexp ? analog_input_eight - vexp
        : vexp - analog_input_eight;
    sequence s_no_clr(a);
        !(reg_wr && reg_addr == a);
    endsequence
    sequence s_lim;
        cpu1_duty_valid && awake && cpu1_duty > cpu1_duty_limit;
    endsequence
    AST_ACK_MAPPED: assert property (acc && mapped |=> reg_ack)
        else $error("no ack on mapped access");
    AST_NO_ACK_UNMAPPED: assert property (acc && !mapped |=> !reg_ack)
        else $error("ack on unmapped access");
    AST_TERM1: assert property ((term1_sense_input && awake) [*6] |-> fault_err_src)
        else $error("terminator 1 fault not latched");
    AST_TERM2: assert property ((term2_sense_input && awake) [*6] |-> fault_err_src)
        else $error("terminator 2 fault not latched");
    AST_CORE2: assert property (($stable(cpu1_voltage_code) [*4]) ##0
        (adc_sample_valid && awake && vdif > VID_TOLERANCE) |=> ##1 fault_err_src)
        else $error("core supply mismatch not latched");
    AST_DIODE: assert property (diode_sample_valid && awake &&
        (diode1_open || diode1_short) ##1 s_no_clr(FAULT_OFS) |=> fault_err_src)
        else $error("diode fault not latched");
    AST_LIMIT: assert property (s_lim ##1 s_no_clr(THROTTLE_OFS) |=> host_err_src)
        else $error("limit event missing on host summary");
    AST_LIMIT_CAUSE: assert property ($rose(host_err_src) |->
        $past(cpu1_duty_valid && awake && cpu1_duty > cpu1_duty_limit, 2))
        else $error("host summary rose without a limit event");
endmodule
bind fts_status_regs fts_status_regs_chk u_chk (.core_clk(core_clk), .rst(rst),
    .term1_sense_input(term1_sense_input), .term2_sense_input(term2_sense_input),
    .cpu1_voltage_code(cpu1_voltage_code), .analog_input_eight(analog_input_eight),
    .adc_sample_valid(adc_sample_valid), .diode1_open(diode1_open),
    .diode1_short(diode1_short), .diode_sample_valid(diode_sample_valid),
    .cpu1_duty(cpu1_duty), .cpu1_duty_limit(cpu1_duty_limit), .reg_addr(reg_addr),
    .cpu1_duty_valid(cpu1_duty_valid), .sleep_s3(sleep_s3), .sleep_s45(sleep_s45),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_ack(reg_ack),
    .host_err_src(host_err_src), .fault_err_src(fault_err_src));

// [bench/fts_host_model.sv]
// host side master of the register byte port
// assumes the bench calls acc and that strobes are single pulses
`timescale 1ns/1ns
module fts_host_model (
    // ---------------------------------------------------------------
    // byte port
    // ---------------------------------------------------------------
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // released lines show the inverse, so stale values never look valid
    task automatic acc(input logic [7:0] a, d, input logic w);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule

// [bench/testbench.sv]
// self-checking bench for the fault and throttle status pair
// assumes the host model and checker are compiled first
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
    import fts_pkg::*;
    // ---------------------------------------------------------------
    // stimulus and scoreboard
    // ---------------------------------------------------------------
    int err_total = 0, tests_run = 0, cyc = 0;
    logic core_clk = 0, rst = 1, term1 = 0, term2 = 0, adc_v = 0, dio_v = 0;
    logic d1o = 0, d1s = 0, d2o = 0, d2s = 0, duty_v = 0, s3 = 0, s45 = 0, rd_d = 0;
    logic [5:0] vid = 6'h05;
    logic [7:0] ain7 = 0, ain8 = 0, duty = 0, lim = 0, rdata, dr, lr;
    logic [9:0] e;
    logic [9:0] expq[$];
    logic [7:0] dtab[13] = '{8'h00, 8'h01, 8'h1f, 8'h20, 8'h3f, 8'h40, 8'h7f,
        8'h80, 8'h81, 8'hbf, 8'hc0, 8'hfe, 8'hff};
    logic [23:0] vtab[3] = '{24'hb6bb20, 24'hbab200, 24'hbbb610};
    logic ack, hes, fes;
    wire [7:0] addr, wdata;
    wire wr, rd;
    always #10 core_clk = ~core_clk;
    fts_host_model u_host (.core_clk(core_clk), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd));
    fts_status_regs u_dut (.core_clk(core_clk), .rst(rst), .term1_sense_input(term1),
        .term2_sense_input(term2), .cpu1_voltage_code(vid), .analog_input_seven(ain7),
        .analog_input_eight(ain8), .adc_sample_valid(adc_v), .diode1_open(d1o),
        .diode1_short(d1s), .diode2_open(d2o), .diode2_short(d2s),
        .diode_sample_valid(dio_v), .cpu1_duty(duty), .cpu1_duty_valid(duty_v),
        .cpu1_duty_limit(lim), .sleep_s3(s3), .sleep_s45(s45), .reg_addr(addr),
        .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .reg_ack(ack),
        .host_err_src(hes), .fault_err_src(fes));
    task automatic tally_and_finish();
        $display("checks %0d, errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        if (ack && rd_d && expq.size() > 0) begin
            e = expq.pop_front();
            `CHK("reg_rdata", e[7:0], rdata)
            `CHK("fault_err_src", e[9], fes)
            `CHK("host_err_src", e[8], hes)
        end
        rd_d <= rd;
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            tally_and_finish();
        end
    end
    function automatic logic [7:0] thr(input logic [7:0] d, l);
        logic [7:0] r;
        r = 8'h00;
        r[0] = d != DUTY_ZERO;
        r[d == DUTY_FULL ? 6 : d >= DUTY_75 ? 5 : d >= DUTY_50 ? 4 : d >= DUTY_25 ? 3
            : d >= DUTY_12P5 ? 2 : 1] = 1'b1;
        r[7] = d > l;
        return r;
    endfunction
    // note: fault summary, host summary, then the register byte
    function automatic logic [9:0] note(input logic [7:0] a, v);
        return {a == FAULT_OFS && |v, a == THROTTLE_OFS && v[LIMIT_BIT], v};
    endfunction
    // read, partial clear, read again, then wipe the rest
    task automatic chk(input logic [7:0] a, x, m);
        repeat (4) @(negedge core_clk);
        expq.push_back(note(a, x));
        u_host.acc(a, 8'h00, 1'b0);
        u_host.acc(a, m, 1'b1);
        expq.push_back(note(a, x & ~m));
        u_host.acc(a, 8'h00, 1'b0);
        u_host.acc(a, 8'hff, 1'b1);
    endtask
    task automatic duty_pulse(input logic [7:0] d, l);
        @(negedge core_clk);
        duty = d;
        lim = l;
        duty_v = 1;
        @(negedge core_clk);
        duty_v = 0;
    endtask
    initial begin
        void'($urandom(30));
        repeat (2) @(posedge core_clk);
        @(negedge core_clk) rst = 0;
        chk(FAULT_OFS, FAULT_RESET, 8'hff);
        chk(THROTTLE_OFS, THROTTLE_RESET, 8'hff);
        u_host.acc(8'h4d, 8'hff, 1'b1);
        foreach (dtab[i]) begin
            duty_pulse(dtab[i], 8'h80);
            chk(THROTTLE_OFS, thr(dtab[i], 8'h80), 8'hff);
        end
        repeat (8) begin
            dr = 8'($urandom);
            lr = 8'($urandom);
            duty_pulse(dr, lr);
            chk(THROTTLE_OFS, thr(dr, lr), 8'($urandom));
        end
        for (int i = 0; i < 2; i++) begin
            @(negedge core_clk);
            {term2, term1} = 2'(i + 1);
            repeat (6) @(negedge core_clk);
            {term2, term1} = 2'b00;
            chk(FAULT_OFS, 8'h04 << i, 8'hff);
        end
        for (int i = 0; i < 4; i++) begin
            @(negedge core_clk);
            {d2s, d2o, d1s, d1o} = 4'(1 << i);
            dio_v = 1;
            @(negedge core_clk);
            dio_v = 0;
            // left high on purpose: only the valid pulse may sample them
            {d2s, d2o, d1s, d1o} = 4'hf;
            chk(FAULT_OFS, i < 2 ? 8'h40 : 8'h80, 8'hff);
        end
        foreach (vtab[i]) begin
            @(negedge core_clk);
            {ain7, ain8} = vtab[i][23:8];
            adc_v = 1;
            @(negedge core_clk);
            adc_v = 0;
            chk(FAULT_OFS, vtab[i][7:0], 8'hff);
        end
        for (int i = 0; i < 2; i++) begin
            {s45, s3} = 2'(i + 1);
            duty_pulse(8'hff, 8'h00);
            chk(THROTTLE_OFS, 8'h00, 8'hff);
            {s45, s3} = 2'b00;
        end
        // a read that never got its ack leaves a note behind
        repeat (4) @(negedge core_clk);
        `CHK("reads pending", 0, expq.size())
        tally_and_finish();
    end
endmodule
